/* File: lcr_pkg.sv */
package lcr_pkg;

   // ==========================================================
   // Reset values and encodings
   // ==========================================================
   localparam logic [5:0] LCR_VOLUME_RST  = 6'h20;  // Mid contrast code.
   localparam logic [2:0] LCR_DIVIDER_RST = 3'h4;   // Gain step 5.0.
   localparam logic [5:0] LCR_LINE_RST    = 6'h00;  // Start line.
   localparam logic [7:0] LCR_COL_RST     = 8'h00;  // Column address.
   localparam logic [3:0] LCR_PAGE_RST    = 4'h0;   // Page address.
   localparam logic [1:0] LCR_BLINK_RST   = 2'h0;   // Indicator blink.

   // Instruction reset keeps the instruction gate shut this many
   // cycles so the busy and reset status bits are visible.
   localparam int         LCR_RST_BUSY_NS  = 200;
   localparam int         LCR_CLK_NS       = 50;
   localparam logic [3:0] LCR_RST_BUSY_CYC =
      4'((LCR_RST_BUSY_NS + LCR_CLK_NS - 1) / LCR_CLK_NS);

   // Gain step table, tenths: 3.0 .. 6.0 by 0.5, then 6.4.
   localparam logic [6:0] LCR_GAIN_BASE = 7'h1E;
   localparam logic [6:0] LCR_GAIN_STEP = 7'h05;
   localparam logic [6:0] LCR_GAIN_TOP  = 7'h40;
   localparam logic [2:0] LCR_CODE_TOP  = 3'h7;

   // Status byte bit positions.
   localparam int LCR_ST_BUSY  = 7;
   localparam int LCR_ST_ADC   = 6;
   localparam int LCR_ST_ONOFF = 5;
   localparam int LCR_ST_RESET = 4;

   // Duty choice from the two pins.
   typedef enum logic [1:0] {
      LCR_DUTY_33 = 2'h0,
      LCR_DUTY_49 = 2'h1,
      LCR_DUTY_55 = 2'h2,
      LCR_DUTY_65 = 2'h3
   } lcr_duty_t;

   // Supply circuit enables, loaded together.
   typedef struct packed {
      logic converter_enable;
      logic regulator_enable;
      logic follower_enable;
   } lcr_power_t;

   // One configuration write from the instruction decoder.
   typedef struct packed {
      logic       power_we;
      lcr_power_t power;
      logic       volume_we;
      logic [5:0] volume_level_bits;
      logic       divider_we;
      logic [2:0] divider_ratio_bits;
      logic       bias_we;
      logic       drive_ratio_select;
      logic       scan_we;
      logic       common_scan_reverse;
      logic       disp_we;
      logic       display_on;
      logic       allon_we;
      logic       all_on;
      logic       adc_we;
      logic       seg_reverse;
      logic       inv_we;
      logic       pixel_invert;
      logic       line_we;
      logic [5:0] start_line;
      logic       col_we;
      logic [7:0] column;
      logic       page_we;
      logic [3:0] page;
      logic       refmode_we;
      logic       refmode;
      logic       static_we;
      logic       static_ind;
      logic       blink_we;
      logic [1:0] indicator_blink_bits;
      logic       modread_we;
      logic       modread;
      logic       osc_we;
      logic       osc_on;
      logic       psave_we;
      logic       psave;
      logic       test_we;
      logic       test;
   } lcr_wr_t;

   // Bias ratio denominator and frame line count per duty.
   typedef struct packed {
      logic [3:0] bias_den;
      logic [6:0] frame_lines;
   } lcr_drive_t;

endpackage

/* File: lcr_pixel_drive.sv */
`timescale 1ns/1ps
module lcr_pixel_drive
   import lcr_pkg::*;
#(
   parameter int N = 132                     // Channel count.
) (
   input  wire logic         clock,          // System clock.
   input  wire logic         arst_n,         // Async reset, low.
   input  wire logic         clk_en,         // Freezes state when low.
   input  wire logic [N-1:0] pixel_bits,     // Display data per channel.
   input  wire logic         ac_inversion_signal, // Frame AC phase.
   input  wire logic         all_on,         // Force every pixel lit while display_on is high.
   input  wire logic         pixel_invert,   // Invert pixel sense.
   input  wire logic         display_on,     // Panel enabled.
   output logic      [N-1:0] drive_level     // Selected drive level.
);

   genvar g;
   // Level is lit-ness XOR the AC phase; blank panel shows phase only.
   generate
      for (g = 0; g < N; g++) begin : g_ch
         wire lit_w = display_on &
                      (all_on | (pixel_bits[g] ^ pixel_invert));
         wire lvl_w = lit_w ^ ac_inversion_signal; // R2
         always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
               drive_level[g] <= 1'b0;
            end else if (clk_en) begin
               drive_level[g] <= lvl_w;
            end
         end
      end
   endgenerate

endmodule

/* File: lcr_supply_ctrl.sv */
`timescale 1ns/1ps
module lcr_supply_ctrl
   import lcr_pkg::*;
(
   input  wire logic       clock,            // System clock.
   input  wire logic       arst_n,           // Async reset, low.
   input  wire logic       clk_en,           // Freezes state when low.
   input  wire lcr_power_t power,            // Enables from instruction.
   input  wire logic       primary_role_select, // Master when high.
   input  wire logic       internal_divider_select, // Internal divider.
   input  wire logic [2:0] divider_ratio_bits, // Divider code.
   input  wire logic       high_power_select_n, // Low: strong drive.
   output lcr_power_t      run,              // Circuits actually running.
   output logic      [6:0] gain_tenths,      // Gain x10, 0 if external.
   output logic            high_drive        // High drive mode.
);

   // Slaves never run their supplies; each enable gates its circuit.
   wire lcr_power_t run_nxt = primary_role_select ? power : '0; // R3 R4

   // Ascending half steps, last step is a special value.
   wire [6:0] step_w = LCR_GAIN_BASE +
                       7'(LCR_GAIN_STEP * 7'(divider_ratio_bits)); // R7
   wire [6:0] gain_w = (divider_ratio_bits == LCR_CODE_TOP) ?
                       LCR_GAIN_TOP : step_w;                     // R7
   // External divider: code does not set the ratio.
   wire [6:0] gain_nxt = internal_divider_select ? gain_w : 7'h00; // R6

   // Applied on the next clock edge after a write.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         run         <= '0;
         gain_tenths <= 7'h00;
         high_drive  <= 1'b0;
      end else if (clk_en) begin
         run         <= run_nxt;        // R26
         gain_tenths <= gain_nxt;       // R26
         high_drive  <= ~high_power_select_n; // R9
      end
   end

endmodule

/* File: lcr_drive_config.sv */
`timescale 1ns/1ps
// What this block does
// R1: 66 common, 132 segment channels.
// R2: Level from pixel and phase.
// R3: Supplies run only as enabled master.
// R4: Three supply circuits gated independently.
// R5: Six-bit volume, default 32.
// R6: Ratio code used with internal divider.
// R7: Eight ascending divider gains.
// R8: Duty pins pick frame length.
// R9: Power pin low gives high drive.
// R10: Reset by pin or instruction.
// R11: Pin reset clears display modes.
// R12: Pin reset clears supply enables.
// R13: Pin reset clears serial, osc, test.
// R14: Pin reset picks lower bias.
// R15: Instruction reset restores a subset.
// R16: Both resets zero line, column, page.
// R17: Both resets reload divider, volume.
// R18: Both resets clear indicator, scan.
// R19: Only status read during reset.
// R20: Reset in progress on status bit.
// R21: Host ties pin reset to own.
// R22: Common scan order reversible.
// R23: One bit picks bias ratio.
// R24: Power enables loaded together.
// R25: Busy rejects instructions.
// R26: Settings apply next clock edge.
module lcr_drive_config
   import lcr_pkg::*;
(
   input  wire logic          clock,          // 20 MHz system clock.
   input  wire logic          arst_n,         // Async reset, low.
   input  wire logic          clk_en,         // Freezes state when low.
   input  wire logic          reset_pin_low_active, // Pin reset, low.
   input  wire logic          reset_instr,    // Reset instruction pulse.
   input  wire lcr_wr_t       wr,             // Configuration writes.
   input  wire logic          ser_bit_valid,  // Serial bit strobe.
   input  wire logic          ser_bit,        // Serial data bit.
   input  wire logic          primary_role_select, // Master when high.
   input  wire logic          internal_divider_select, // Divider pin.
   input  wire logic [1:0]    lcd_cycle_fraction_pins, // Duty pins.
   input  wire logic          high_power_select_n, // Drive strength pin.
   input  wire logic          ac_inversion_signal, // Frame AC phase.
   input  wire logic [131:0]  seg_pixels,     // Segment pixel data.
   input  wire logic [65:0]   com_select,     // Active common line.
   output logic      [131:0]  seg_drive,      // Segment drive levels.
   output logic      [65:0]   com_drive,      // Common drive levels.
   output logic      [7:0]    status,         // Status byte.
   output logic               accept_en,      // Instructions allowed.
   output lcr_power_t         supply_run,     // Running supply circuits.
   output logic      [6:0]    gain_tenths,    // Divider gain x10.
   output logic               high_drive,     // High drive mode.
   output logic      [5:0]    volume_level_bits, // Contrast level.
   output logic      [2:0]    divider_ratio_bits, // Divider code.
   output lcr_drive_t         drive_cfg,      // Bias and duty length.
   output logic               common_scan_reverse, // Scan reversed.
   output logic      [5:0]    start_line,     // Display start line.
   output logic      [7:0]    column,         // Column address.
   output logic      [3:0]    page,           // Page address.
   output logic      [1:0]    indicator_blink_bits, // Indicator blink.
   output logic               static_ind,     // Static indicator mode.
   output logic               modread,        // Modify-read mode.
   output logic               refmode,        // Ref voltage set pending.
   output logic               osc_on,         // Oscillator running.
   output logic               psave,          // Power save active.
   output logic               test_mode,      // Test mode.
   output logic      [7:0]    ser_shift,      // Serial shift register.
   output logic      [2:0]    ser_count       // Serial bit counter.
);

   // ====================
   // Input synchronisers
   // The reset pin and straps are foreign to this clock, so each
   // passes two flops before any logic looks at it.
   logic [5:0] sync1_r;             // First stage, feeds stage two only.
   logic [5:0] sync2_r;             // Second stage, safe to read.
   wire  [5:0] pins_w = {reset_pin_low_active, primary_role_select,
                         internal_divider_select, lcd_cycle_fraction_pins,
                         high_power_select_n};

   // Pin and strap synchroniser; both stages reset low, so the pin reads as a pin reset until its high level passes through.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sync1_r <= 6'h00;
         sync2_r <= 6'h00;
      end else if (clk_en) begin
         sync1_r <= pins_w;
         sync2_r <= sync1_r;
      end
   end

   wire       pin_rst_w = ~sync2_r[5];    // R10
   wire       master_w  = sync2_r[4];
   wire       intdiv_w  = sync2_r[3];
   wire [1:0] duty_w    = sync2_r[2:1];
   wire       hpm_n_w   = sync2_r[0];

   // ====================
   // Instruction reset sequencing
   // A reset instruction holds the busy gate a few cycles; a reset
   // instruction arriving while busy is simply absorbed.
   logic [3:0] rst_cnt_r;            // Remaining busy cycles.
   wire        ins_rst_w = reset_instr & accept_en;          // R10
   wire        busy_w    = pin_rst_w | (rst_cnt_r != 4'h0) |
                           ins_rst_w;
   wire [3:0]  rst_cnt_nxt = ins_rst_w ? LCR_RST_BUSY_CYC :
                             (rst_cnt_r != 4'h0) ? rst_cnt_r - 4'h1 :
                             4'h0;
   wire        any_rst_w = pin_rst_w | ins_rst_w;
   // Writes land only when the gate is open.
   wire        we_ok_w   = accept_en & ~ins_rst_w;          // R19 R25

   // Busy counter.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rst_cnt_r <= 4'h0;
      end else if (clk_en) begin
         rst_cnt_r <= pin_rst_w ? 4'h0 : rst_cnt_nxt;
      end
   end

   // ====================
   // Pin-reset-only state
   // These survive an instruction reset and clear only on the pin.
   logic disp_on_r, all_on_r, seg_rev_r, inv_r, bias_sel_r;
   lcr_power_t power_r;              // Supply enables as written.

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         disp_on_r  <= 1'b0;
         all_on_r   <= 1'b0;
         seg_rev_r  <= 1'b0;
         inv_r      <= 1'b0;
         power_r    <= '0;
         bias_sel_r <= 1'b0;
         osc_on     <= 1'b0;
         psave      <= 1'b0;
      end else if (clk_en) begin
         if (pin_rst_w) begin
            disp_on_r  <= 1'b0;     // R11
            all_on_r   <= 1'b0;     // R11
            seg_rev_r  <= 1'b0;     // R11
            inv_r      <= 1'b0;     // R11
            power_r    <= '0;       // R12
            bias_sel_r <= 1'b0;     // R14
            osc_on     <= 1'b0;     // R13
            psave      <= 1'b0;     // R13
         end else if (we_ok_w) begin // R15
            if (wr.disp_we)  disp_on_r  <= wr.display_on;
            if (wr.allon_we) all_on_r   <= wr.all_on;
            if (wr.adc_we)   seg_rev_r  <= wr.seg_reverse;
            if (wr.inv_we)   inv_r      <= wr.pixel_invert;
            if (wr.power_we) power_r    <= wr.power;        // R24
            if (wr.bias_we)  bias_sel_r <= wr.drive_ratio_select; // R23
            if (wr.osc_we)   osc_on     <= wr.osc_on;
            if (wr.psave_we) psave      <= wr.psave;
         end
      end
   end

   // ====================
   // State restored by both reset sources
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         volume_level_bits    <= LCR_VOLUME_RST;
         divider_ratio_bits   <= LCR_DIVIDER_RST;
         start_line           <= LCR_LINE_RST;
         column               <= LCR_COL_RST;
         page                 <= LCR_PAGE_RST;
         indicator_blink_bits <= LCR_BLINK_RST;
         static_ind           <= 1'b0;
         modread              <= 1'b0;
         common_scan_reverse  <= 1'b0;
         refmode              <= 1'b0;
         test_mode            <= 1'b0;
      end else if (clk_en) begin
         if (any_rst_w) begin
            start_line           <= LCR_LINE_RST;     // R16
            column               <= LCR_COL_RST;      // R16
            page                 <= LCR_PAGE_RST;     // R16
            divider_ratio_bits   <= LCR_DIVIDER_RST;  // R17
            volume_level_bits    <= LCR_VOLUME_RST;   // R5 R17
            refmode              <= 1'b0;             // R17
            static_ind           <= 1'b0;             // R18
            indicator_blink_bits <= LCR_BLINK_RST;    // R18
            modread              <= 1'b0;             // R18
            common_scan_reverse  <= 1'b0;             // R18
            test_mode            <= 1'b0;             // R13
         end else if (we_ok_w) begin
            if (wr.volume_we)  volume_level_bits  <= wr.volume_level_bits;
            if (wr.divider_we) divider_ratio_bits <= wr.divider_ratio_bits;
            if (wr.line_we)    start_line <= wr.start_line;
            if (wr.col_we)     column     <= wr.column;
            if (wr.page_we)    page       <= wr.page;
            if (wr.refmode_we) refmode    <= wr.refmode;
            if (wr.static_we)  static_ind <= wr.static_ind;
            if (wr.blink_we)   indicator_blink_bits <=
                                  wr.indicator_blink_bits;
            if (wr.modread_we) modread    <= wr.modread;
            if (wr.scan_we)    common_scan_reverse <=
                                  wr.common_scan_reverse;   // R22
            if (wr.test_we)    test_mode  <= wr.test;
         end
      end
   end

   // ====================
   // Serial receiver state
   // The pin reset wipes any half-shifted byte.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ser_shift <= 8'h00;
         ser_count <= 3'h0;
      end else if (clk_en) begin
         if (pin_rst_w) begin
            ser_shift <= 8'h00;     // R13
            ser_count <= 3'h0;      // R13
         end else if (ser_bit_valid) begin
            ser_shift <= {ser_shift[6:0], ser_bit};
            ser_count <= ser_count + 3'h1;
         end
      end
   end

   // ====================
   // Duty and bias decode
   // Larger denominator when the ratio bit is clear.
   lcr_drive_t drive_nxt;
   always_comb begin
      drive_nxt = '0;
      case (lcr_duty_t'(duty_w))                               // R8
         LCR_DUTY_33: drive_nxt = {bias_sel_r ? 4'h5 : 4'h6, 7'h21};
         LCR_DUTY_49: drive_nxt = {bias_sel_r ? 4'h6 : 4'h8, 7'h31};
         LCR_DUTY_55: drive_nxt = {bias_sel_r ? 4'h6 : 4'h8, 7'h37};
         LCR_DUTY_65: drive_nxt = {bias_sel_r ? 4'h7 : 4'h9, 7'h41};
         default:     drive_nxt = '0;
      endcase
   end

   // ====================
   // Common line scan and status
   // Common 0..63 reverse as a block; the two icon commons stay put.
   logic [65:0] com_sel_w;
   genvar c;
   generate
      for (c = 0; c < 64; c++) begin : g_com
         assign com_sel_w[c] = common_scan_reverse ?
                               com_select[63-c] : com_select[c]; // R22
      end
   endgenerate
   assign com_sel_w[65:64] = com_select[65:64];                // R1

   wire [7:0] status_nxt = {busy_w, ~seg_rev_r, ~disp_on_r,
                            pin_rst_w | (rst_cnt_r != 4'h0), 4'h0}; // R20

   // Registered status and gate outputs.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         status    <= 8'h00;
         accept_en <= 1'b0;
         drive_cfg <= '0;
      end else if (clk_en) begin
         status    <= status_nxt;    // R20 R25
         accept_en <= ~busy_w;       // R19 R25
         drive_cfg <= drive_nxt;
      end
   end

   // ====================
   // Submodules
   lcr_supply_ctrl u_supply (
      .clock                   (clock),
      .arst_n                  (arst_n),
      .clk_en                  (clk_en),
      .power                   (power_r),
      .primary_role_select     (master_w),
      .internal_divider_select (intdiv_w),
      .divider_ratio_bits      (divider_ratio_bits),
      .high_power_select_n     (hpm_n_w),
      .run                     (supply_run),
      .gain_tenths             (gain_tenths),
      .high_drive              (high_drive)
   );

   lcr_pixel_drive #(.N(132)) u_seg (
      .clock               (clock),
      .arst_n              (arst_n),
      .clk_en              (clk_en),
      .pixel_bits          (seg_pixels),
      .ac_inversion_signal (ac_inversion_signal),
      .all_on              (all_on_r),
      .pixel_invert        (inv_r),
      .display_on          (disp_on_r),
      .drive_level         (seg_drive)
   );

   // Commons use the same level rule with the scan select as data.
   lcr_pixel_drive #(.N(66)) u_com (
      .clock               (clock),
      .arst_n              (arst_n),
      .clk_en              (clk_en),
      .pixel_bits          (com_sel_w),
      .ac_inversion_signal (ac_inversion_signal),
      .all_on              (1'b0),
      .pixel_invert        (1'b0),
      .display_on          (disp_on_r),
      .drive_level         (com_drive)
   );

endmodule

/* File: lcr_host.sv */
`timescale 1ns/1ps
module lcr_host
   import lcr_pkg::*;
(
   input  wire logic       clock,       // System clock.
   input  wire logic       cpu_rst_n,   // Host reset, low.
   input  wire logic       accept_en,   // Device ready.
   input  wire logic [7:0] status,      // Status byte.
   output logic            rst_pin_n,   // Device pin reset.
   output lcr_wr_t         wr,          // Configuration write.
   output logic            reset_instr  // Reset instruction.
);
   // The device pin follows the host reset.
   assign rst_pin_n = cpu_rst_n;
   initial begin
      wr = '0;
      reset_instr = 1'b0;
   end
   // Polls at the falling edge, where status has settled, then holds
   // the request for one full cycle.
   task automatic put(input lcr_wr_t w, input logic ri, input logic rdy);
      int n;
      n = 0;
      @(negedge clock);
      while (rdy && n < 99 && (status[7] !== 1'b0 ||
             status[4] !== 1'b0 || accept_en !== 1'b1)) begin
         @(negedge clock);
         n++;
      end
      @(posedge clock);
      wr <= w;
      reset_instr <= ri;
      @(posedge clock);
      wr <= '0;
      reset_instr <= 1'b0;
   endtask
endmodule

/* File: lcr_drive_config_assertions.sv */
`timescale 1ns/1ps
module lcr_chk
   import lcr_pkg::*;
(
   input wire logic       clock,                // Clock.
   input wire logic       arst_n,               // Reset, low.
   input wire logic       clk_en,               // Run enable.
   input wire logic       reset_pin_low_active, // Pin reset, low.
   input wire logic       reset_instr,          // Reset instruction.
   input wire lcr_wr_t    wr,                   // Writes.
   input wire logic       primary_role_select,  // Master strap.
   input wire logic [7:0] status,               // Status byte.
   input wire logic       accept_en,            // Ready.
   input wire lcr_power_t supply_run,           // Running supplies.
   input wire logic [5:0] volume_level_bits,    // Volume.
   input wire logic [2:0] divider_ratio_bits,   // Divider code.
   input wire lcr_drive_t drive_cfg,            // Bias and duty.
   input wire logic       common_scan_reverse,  // Scan reversed.
   input wire logic       osc_on,               // Oscillator.
   input wire logic [2:0] ser_count             // Serial count.
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   logic go_w; // An instruction is taken at this edge.
   assign go_w = clk_en && accept_en && reset_pin_low_active;
   a_instr_vals: assert property (reset_instr && go_w |=>
      volume_level_bits == LCR_VOLUME_RST && !common_scan_reverse &&
      divider_ratio_bits == LCR_DIVIDER_RST) else $error("reset values");
   a_instr_gate: assert property (reset_instr && go_w |=>
      (!accept_en)[*4] ##[1:2] accept_en) else $error("busy window");
   a_instr_stat: assert property (reset_instr && go_w |->
      ##[1:2] (status[7] && status[4])) else $error("status bits");
   a_instr_keep: assert property (reset_instr && go_w |=>
      osc_on == $past(osc_on)) else $error("oscillator disturbed");
   a_vol_write: assert property (wr.volume_we && go_w && !reset_instr |=>
      volume_level_bits == $past(wr.volume_level_bits))
      else $error("volume not stored");
   a_pin_clear: assert property ((!reset_pin_low_active && clk_en)[*6] |->
      supply_run == '0 && !osc_on && ser_count == 3'h0)
      else $error("pin reset state");
   a_pin_gate: assert property ((!reset_pin_low_active && clk_en)[*4] |->
      !accept_en && status[4]) else $error("pin gate");
   a_pin_bias: assert property ((!reset_pin_low_active && clk_en)[*6] |->
      drive_cfg.bias_den == (drive_cfg.frame_lines == 7'h41 ? 4'h9 :
      drive_cfg.frame_lines == 7'h21 ? 4'h6 : 4'h8)) else $error("bias");
   a_slave_off: assert property ((!primary_role_select && clk_en)[*5] |->
      supply_run == '0) else $error("supply runs as slave");
endmodule
bind lcr_drive_config lcr_chk i_chk (.*);

/* File: test_lcd_drive_config_and_reset.sv */
`timescale 1ns/1ps
module test_lcd_drive_config_and_reset;
   import lcr_pkg::*;
   logic clock, arst_n, clk_en, cpu_rst_n, reset_pin_low_active, reset_instr;
   logic ser_bit_valid, ser_bit, primary_role_select, internal_divider_select;
   logic high_power_select_n, ac_inversion_signal, accept_en, high_drive;
   logic common_scan_reverse, static_ind, modread, refmode, osc_on, psave;
   logic test_mode;
   logic [1:0] lcd_cycle_fraction_pins, indicator_blink_bits;
   logic [131:0] seg_pixels, seg_drive;
   logic [65:0] com_select, com_drive;
   logic [7:0] status, column, ser_shift;
   logic [6:0] gain_tenths;
   logic [5:0] volume_level_bits, start_line;
   logic [3:0] page;
   logic [2:0] divider_ratio_bits, ser_count;
   lcr_wr_t wr, w;
   lcr_power_t supply_run;
   lcr_drive_t drive_cfg;
   int error_cnt, checks_done;
   lcr_drive_config i_dut (.*);
   lcr_host i_host (.clock(clock), .cpu_rst_n(cpu_rst_n),
      .accept_en(accept_en), .status(status), .wr(wr),
      .rst_pin_n(reset_pin_low_active), .reset_instr(reset_instr));
   always #25 clock = ~clock;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Four enable codes, then the master strap is dropped.
   task automatic t_power();
      logic [2:0] c [4] = '{3'h3, 3'h1, 3'h0, 3'h7};
      foreach (c[i]) begin
         w = '0;
         w.power_we = 1'b1;
         w.power = c[i];
         i_host.put(w, 1'b0, 1'b1);
         repeat (2) @(negedge clock);
         chk(supply_run, c[i]);
      end
      @(posedge clock) primary_role_select <= 1'b0;
      repeat (5) @(negedge clock);
      chk(supply_run, 8'h00);
      @(posedge clock) primary_role_select <= 1'b1;
   endtask
   // Every divider code, then external divider and strong drive.
   task automatic t_gain();
      for (int k = 0; k < 8; k++) begin
         w = '0;
         w.divider_we = 1'b1;
         w.divider_ratio_bits = k[2:0];
         i_host.put(w, 1'b0, 1'b1);
         repeat (2) @(negedge clock);
         chk(gain_tenths, k == 7 ? 8'h40 : 8'(8'h1E + 8'h05 * k));
      end
      @(posedge clock) internal_divider_select <= 1'b0;
      high_power_select_n <= 1'b0;
      repeat (5) @(negedge clock);
      chk(gain_tenths, 8'h00);
      chk(high_drive, 8'h01);
   endtask
   // Reset instruction, then a write refused while busy.
   task automatic t_instr();
      w = '0;
      {w.volume_we, w.scan_we, w.osc_we, w.col_we, w.page_we} = 5'h1F;
      {w.common_scan_reverse, w.osc_on, w.page} = 6'h3F;
      {w.volume_level_bits, w.column} = 14'h3F83;
      i_host.put(w, 1'b0, 1'b1);
      i_host.put('0, 1'b1, 1'b1);
      i_host.put(w, 1'b0, 1'b0);
      @(negedge clock);
      chk(accept_en, 8'h00);
      chk(status[7], 8'h01);
      chk(osc_on, 8'h01);
      chk(common_scan_reverse, 8'h00);
      chk(column, 8'h00);
      chk(page, 8'h00);
      i_host.put('0, 1'b0, 1'b1);
      chk(volume_level_bits, 8'h20);
   endtask
   // Serial bits, then a pin reset at every duty setting.
   task automatic t_pin();
      logic [7:0] fl [4] = '{8'h21, 8'h31, 8'h37, 8'h41};
      logic [7:0] bd [4] = '{8'h06, 8'h08, 8'h08, 8'h09};
      repeat (3) begin
         @(posedge clock) ser_bit_valid <= 1'b1;
         ser_bit <= 1'b1;
         @(posedge clock) ser_bit_valid <= 1'b0;
      end
      @(negedge clock);
      chk(ser_shift, 8'h07);
      for (int d = 0; d < 4; d++) begin
         @(posedge clock) lcd_cycle_fraction_pins <= d[1:0];
         ac_inversion_signal <= 1'b1;
         cpu_rst_n <= 1'b0;
         repeat (8) @(negedge clock);
         chk(status[4], 8'h01);
         chk({supply_run, osc_on, ser_count}, 8'h00);
         chk(drive_cfg.frame_lines, fl[d]);
         chk(drive_cfg.bias_den, bd[d]);
         chk(8'(&{seg_drive, com_drive}), 8'h01);
         @(posedge clock) cpu_rst_n <= 1'b1;
      end
   endtask
   initial begin
      {clock, arst_n, cpu_rst_n, ser_bit_valid, ser_bit} = '0;
      {clk_en, primary_role_select, internal_divider_select} = 3'h7;
      {high_power_select_n, ac_inversion_signal} = 2'h2;
      lcd_cycle_fraction_pins = 2'h3;
      seg_pixels = '1;
      com_select = '0;
      error_cnt = 0;
      checks_done = 0;
      repeat (10) @(posedge clock);
      arst_n <= 1'b1;
      cpu_rst_n <= 1'b1;
      t_power();
      t_gain();
      t_instr();
      t_pin();
      test_done();
   end
   // Cuts a hang short well beyond the expected run of about 125 cycles.
   initial begin
      #3000000;
      error_cnt++;
      test_done();
   end
endmodule
